// [rtl/pcd_change_detector.sv]
/*
 pressure change detector: sample intake with saturation, pressure fifo,
 fixed / relative / slope algorithms, sticky flags and avalon-mm registers.
 assumes samples come one-cycle pulsed from logic on the same clock.
*/
`timescale 1ns/1ns
module pcd_change_detector #(
    parameter int RAW_W = 17,
    parameter logic [pcd_pkg::PW-1:0] PMAX = 16'hFFFF,
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // register bus
    input wire pcd_pkg::pcd_avreq_t avReq,
    output logic [31:0] avReadData,
    output logic avWaitRequest,
    // pressure sample from the measurement chain
    input wire logic sampleValid,
    input wire logic [RAW_W-1:0] sampleRaw,
    // event outputs
    output pcd_pkg::pcd_flags_t eventFlags,
    output logic notifyFlag,
    output logic pressureOverflow
);
    localparam int SELW = $clog2(FIFO_DEPTH);
    localparam int MW = pcd_pkg::PW + pcd_pkg::CW + 1;

    pcd_pkg::pcd_cfg_t cfg;
    pcd_pkg::pcd_state_t state;
    logic [pcd_pkg::CW-1:0] debThr;
    logic [pcd_pkg::PW-1:0] fixThr;
    logic [pcd_pkg::CW-1:0] minThr;
    logic [pcd_pkg::PW-1:0] relThr;
    logic [pcd_pkg::PW-1:0] slopeThr;
    logic [SELW-1:0] fifoSel;
    logic [pcd_pkg::PW-1:0] fifoMem [FIFO_DEPTH];
    logic [pcd_pkg::CW-1:0] fixCnt;
    logic [pcd_pkg::CW-1:0] relCnt;
    logic [pcd_pkg::CW-1:0] slopeCnt;
    logic [pcd_pkg::CW-1:0] slopePer;
    logic [pcd_pkg::PW-1:0] relRef;
    logic [pcd_pkg::PW-1:0] slopeRef;

    function automatic logic [pcd_pkg::CW-1:0] stepCnt(
        input logic [pcd_pkg::CW-1:0] cnt,
        input logic up
    );
        logic [pcd_pkg::CW-1:0] r;
        r = cnt;
        if (up) begin
            if (cnt != {pcd_pkg::CW{1'b1}}) begin
                r = cnt + 1'b1;
            end
        end else if (cnt != '0) begin
            r = cnt - 1'b1;
        end
        return r;
    endfunction

    function automatic logic [pcd_pkg::PW-1:0] riseOf(
        input logic [pcd_pkg::PW-1:0] cur,
        input logic [pcd_pkg::PW-1:0] base
    );
        return (cur > base) ? cur - base : '0;
    endfunction

    function automatic logic [31:0] beMerge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0] be
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction

    // bus side
    logic wrDone;
    logic ack;
    logic [31:0] rdMux;
    logic [31:0] wrMerged;

    assign wrDone = avReq.write && !avWaitRequest;
    assign ack = wrDone && avReq.address == pcd_pkg::OFS_CMD
        && avReq.byteenable[0] && avReq.writedata[pcd_pkg::CMD_ACK];
    assign wrMerged = beMerge(rdMux, avReq.writedata, avReq.byteenable);

    always_comb begin
        rdMux = 32'h0000_0000;
        case (avReq.address)
            pcd_pkg::OFS_CFG: rdMux[3:0] = cfg;
            pcd_pkg::OFS_DEBT: rdMux[pcd_pkg::CW-1:0] = debThr;
            pcd_pkg::OFS_FIXT: rdMux[pcd_pkg::PW-1:0] = fixThr;
            pcd_pkg::OFS_MINT: rdMux[pcd_pkg::CW-1:0] = minThr;
            pcd_pkg::OFS_RELT: rdMux[pcd_pkg::PW-1:0] = relThr;
            pcd_pkg::OFS_SLOPET: rdMux[pcd_pkg::PW-1:0] = slopeThr;
            pcd_pkg::OFS_STATUS: rdMux[3:0] = {notifyFlag, eventFlags};
            pcd_pkg::OFS_SENSTAT: rdMux[pcd_pkg::SEN_PRESSURE_OVERFLOW_BIT] = pressureOverflow;
            pcd_pkg::OFS_FIFOSEL: rdMux[SELW-1:0] = fifoSel;
            pcd_pkg::OFS_FIFODATA: rdMux[pcd_pkg::PW-1:0] = fifoMem[fifoSel];
            default: rdMux = 32'h0000_0000;
        endcase
    end

    // one wait cycle, then the answer stands for one cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            avWaitRequest <= 1'b1;
            avReadData <= 32'h0000_0000;
        end else if ((avReq.read || avReq.write) && avWaitRequest) begin
            avWaitRequest <= 1'b0;
            avReadData <= avReq.read ? rdMux : 32'h0000_0000;
        end else begin
            avWaitRequest <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cfg <= pcd_pkg::RST_CFG;
            debThr <= pcd_pkg::RST_DEBT;
            fixThr <= pcd_pkg::RST_FIXT;
            minThr <= pcd_pkg::RST_MINT;
            relThr <= pcd_pkg::RST_RELT;
            slopeThr <= pcd_pkg::RST_SLOPET;
            fifoSel <= '0;
        end else if (wrDone) begin
            case (avReq.address)
                pcd_pkg::OFS_CFG: cfg <= wrMerged[3:0];
                pcd_pkg::OFS_DEBT: debThr <= wrMerged[pcd_pkg::CW-1:0];
                pcd_pkg::OFS_FIXT: fixThr <= wrMerged[pcd_pkg::PW-1:0];
                pcd_pkg::OFS_MINT: minThr <= wrMerged[pcd_pkg::CW-1:0];
                pcd_pkg::OFS_RELT: relThr <= wrMerged[pcd_pkg::PW-1:0];
                pcd_pkg::OFS_SLOPET: slopeThr <= wrMerged[pcd_pkg::PW-1:0];
                pcd_pkg::OFS_FIFOSEL: fifoSel <= wrMerged[SELW-1:0];
                default: ;
            endcase
        end
    end

    // sample intake
    logic accept;
    logic overNow;
    logic [pcd_pkg::PW-1:0] satVal;

    assign accept = state == pcd_pkg::PCD_IDLE && sampleValid;
    assign overNow = sampleRaw > RAW_W'(PMAX);
    assign satVal = overNow ? PMAX : sampleRaw[pcd_pkg::PW-1:0];

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state <= pcd_pkg::PCD_IDLE;
        end else begin
            unique case (state)
                pcd_pkg::PCD_IDLE: begin
                    if (sampleValid) begin
                        state <= pcd_pkg::PCD_EVAL;
                    end
                end
                pcd_pkg::PCD_EVAL: state <= pcd_pkg::PCD_SLOPE;
                pcd_pkg::PCD_SLOPE: state <= pcd_pkg::PCD_IDLE;
                default: state <= pcd_pkg::PCD_IDLE;
            endcase
        end
    end

    // fifo keeps shifting whatever the flags show
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < FIFO_DEPTH; i++) begin
                fifoMem[i] <= '0;
            end
        end else if (accept) begin
            fifoMem[0] <= satVal;
            for (int i = 1; i < FIFO_DEPTH; i++) begin
                fifoMem[i] <= fifoMem[i-1];
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pressureOverflow <= 1'b0;
        end else if (accept) begin
            pressureOverflow <= overNow;
        end else if (ack) begin
            pressureOverflow <= 1'b0;
        end
    end

    // algorithm datapath
    logic [pcd_pkg::PW-1:0] curr;
    logic [pcd_pkg::PW-1:0] prev;
    logic incr;
    logic [pcd_pkg::PW-1:0] relRise;
    logic [pcd_pkg::CW-1:0] next_fixCnt;
    logic [pcd_pkg::CW-1:0] next_relCnt;
    logic [pcd_pkg::CW-1:0] next_slopeCnt;
    logic [MW-1:0] slopeLhs;
    logic [MW-1:0] slopeRhs;
    logic setFix;
    logic setRel;
    logic setSlope;

    assign curr = fifoMem[0];
    assign prev = fifoMem[1];
    assign incr = {1'b0, curr} > {1'b0, prev} + (pcd_pkg::PW+1)'(minThr);
    assign relRise = riseOf(curr, relCnt == '0 ? prev : relRef);
    assign next_fixCnt = stepCnt(fixCnt, curr > fixThr);
    assign next_relCnt = stepCnt(relCnt, incr && relRise > relThr);
    assign next_slopeCnt = stepCnt(slopeCnt, incr);
    // floor division compare: rise*128/(n+1) >= thr
    assign slopeLhs = MW'({riseOf(curr, slopeRef),
        {pcd_pkg::SLOPE_SHIFT{1'b0}}});
    assign slopeRhs = MW'(slopeThr) * MW'({1'b0, slopePer} + 1'b1);
    assign setFix = state == pcd_pkg::PCD_EVAL && cfg.fixEn
        && next_fixCnt > debThr;
    assign setRel = state == pcd_pkg::PCD_EVAL && cfg.relEn
        && next_relCnt > debThr;
    assign setSlope = state == pcd_pkg::PCD_SLOPE && cfg.slopeEn
        && slopeCnt > debThr && slopeLhs >= slopeRhs;

    // each algorithm owns its counter; relative and slope also own a reference
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            fixCnt <= '0;
        end else if (state == pcd_pkg::PCD_EVAL) begin
            fixCnt <= cfg.fixEn ? next_fixCnt : '0;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            relCnt <= '0;
            relRef <= '0;
        end else if (state == pcd_pkg::PCD_EVAL) begin
            relCnt <= cfg.relEn ? next_relCnt : '0;
            if (relCnt == '0 && next_relCnt != '0) begin
                relRef <= prev;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            slopeCnt <= '0;
            slopeRef <= '0;
            slopePer <= '0;
        end else if (state == pcd_pkg::PCD_EVAL) begin
            slopeCnt <= cfg.slopeEn ? next_slopeCnt : '0;
            if (slopeCnt == '0 && next_slopeCnt != '0) begin
                slopeRef <= prev;
                slopePer <= 8'h01;
            end else if (slopePer != 8'hFF) begin
                slopePer <= slopePer + 1'b1;
            end
        end
    end

    // sticky flags, set wins over acknowledge
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            eventFlags <= '0;
        end else begin
            eventFlags.fix <= (eventFlags.fix && !ack) || setFix;
            eventFlags.rel <= (eventFlags.rel && !ack) || setRel;
            eventFlags.slope <= (eventFlags.slope && !ack) || setSlope;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            notifyFlag <= 1'b0;
        end else begin
            notifyFlag <= (notifyFlag && !ack) || setFix || setRel
                || setSlope
                || (accept && overNow && cfg.sensErrEn);
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    AST_ONE_PASS: assert property (
        accept |=> state == pcd_pkg::PCD_EVAL
            ##1 state == pcd_pkg::PCD_SLOPE ##1 state == pcd_pkg::PCD_IDLE)
        else $error("sample pass not three cycles");
    AST_SAT: assert property (
        accept && overNow |=> curr == PMAX && pressureOverflow)
        else $error("overrange sample not saturated");
    AST_OVF_QUIET: assert property (
        accept && !cfg.sensErrEn && !notifyFlag && !setFix && !setRel
            && !setSlope |=> !notifyFlag)
        else $error("notify raised without trigger enable");
    AST_FIX_OFF: assert property (
        state == pcd_pkg::PCD_EVAL && !cfg.fixEn |=> fixCnt == '0)
        else $error("disabled fixed counter moved");
    AST_FIX_STEP: assert property (
        state == pcd_pkg::PCD_EVAL && cfg.fixEn && curr <= fixThr
            && fixCnt != '0 |=> fixCnt == $past(fixCnt) - 1'b1)
        else $error("fixed counter did not decrement");
    AST_FIX_SET: assert property (
        state == pcd_pkg::PCD_EVAL && cfg.fixEn && debThr == '0
            && curr > fixThr |=> eventFlags.fix && notifyFlag)
        else $error("fixed flag missed at zero debounce");
    AST_STICKY: assert property (
        eventFlags.rel && !ack |=> eventFlags.rel)
        else $error("relative flag dropped without ack");
    AST_ACK: assert property (
        ack && !setFix |=> !eventFlags.fix)
        else $error("ack did not clear fixed flag");
    AST_SLOPE_SET: assert property (
        setSlope |=> eventFlags.slope && state == pcd_pkg::PCD_IDLE)
        else $error("slope flag not set");
    AST_SLOPE_NOINC: assert property (
        state == pcd_pkg::PCD_EVAL && cfg.slopeEn && !incr
            && slopeCnt != '0 |=> slopeCnt == $past(slopeCnt) - 1'b1)
        else $error("slope counter did not decrement");
    AST_FIX_UP: assert property (
        state == pcd_pkg::PCD_EVAL && cfg.fixEn && curr > fixThr
            && fixCnt != 8'hFF |=> fixCnt == $past(fixCnt) + 1'b1)
        else $error("fixed counter did not increment");
    AST_NOTIFY_ANY: assert property (
        eventFlags != '0 |-> notifyFlag)
        else $error("event flag without notify");
    AST_FIFO_SHIFT: assert property (
        accept |=> fifoMem[1] == $past(fifoMem[0]))
        else $error("fifo did not shift on sample");
    AST_NO_PASS: assert property (
        state == pcd_pkg::PCD_IDLE && !sampleValid
            |=> state == pcd_pkg::PCD_IDLE)
        else $error("algorithms ran without a sample");
    AST_REL_OFF: assert property (
        state == pcd_pkg::PCD_EVAL && !cfg.relEn |=> relCnt == '0)
        else $error("disabled relative counter moved");
    AST_REL_UP: assert property (
        state == pcd_pkg::PCD_EVAL && cfg.relEn && incr && relRise > relThr
            && relCnt != 8'hFF |=> relCnt == $past(relCnt) + 1'b1)
        else $error("relative counter did not increment");
    AST_SLOPE_OFF: assert property (
        state == pcd_pkg::PCD_EVAL && !cfg.slopeEn |=> slopeCnt == '0)
        else $error("disabled slope counter moved");
    AST_SLOPE_GATE: assert property (
        state == pcd_pkg::PCD_SLOPE && slopeCnt <= debThr
            |=> !$rose(eventFlags.slope))
        else $error("slope flag set below debounce count");
endmodule

// [rtl/pcd_pkg.sv]
/*
 pressure change detector: shared constants, register map and carrier types.
 assumes a 32-bit avalon-mm slave with byte addresses, one word per register.
*/
package pcd_pkg;
    // widths
    localparam int PW = 16;
    localparam int CW = 8;
    localparam int AW = 6;
    localparam int SLOPE_SHIFT = 7;
    // register byte offsets
    localparam logic [AW-1:0] OFS_CFG = 6'h00;
    localparam logic [AW-1:0] OFS_DEBT = 6'h04;
    localparam logic [AW-1:0] OFS_FIXT = 6'h08;
    localparam logic [AW-1:0] OFS_MINT = 6'h0C;
    localparam logic [AW-1:0] OFS_RELT = 6'h10;
    localparam logic [AW-1:0] OFS_SLOPET = 6'h14;
    localparam logic [AW-1:0] OFS_STATUS = 6'h18;
    localparam logic [AW-1:0] OFS_SENSTAT = 6'h1C;
    localparam logic [AW-1:0] OFS_CMD = 6'h20;
    localparam logic [AW-1:0] OFS_FIFOSEL = 6'h24;
    localparam logic [AW-1:0] OFS_FIFODATA = 6'h28;
    // field positions
    localparam int ST_NOTIFY = 3;
    localparam int SEN_PRESSURE_OVERFLOW_BIT = 0;
    localparam int CMD_ACK = 0;
    // reset values
    localparam logic [3:0] RST_CFG = 4'h1;
    localparam logic [CW-1:0] RST_DEBT = 8'h05;
    localparam logic [PW-1:0] RST_FIXT = 16'h0320;
    localparam logic [CW-1:0] RST_MINT = 8'h03;
    localparam logic [PW-1:0] RST_RELT = 16'h0032;
    localparam logic [PW-1:0] RST_SLOPET = 16'h0040;

    // bit 0 fixed, 1 relative, 2 slope, 3 sensor error trigger
    typedef struct packed {
        logic sensErrEn;
        logic slopeEn;
        logic relEn;
        logic fixEn;
    } pcd_cfg_t;

    typedef struct packed {
        logic slope;
        logic rel;
        logic fix;
    } pcd_flags_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [AW-1:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } pcd_avreq_t;

    typedef enum logic [1:0] {
        PCD_IDLE = 2'b00,
        PCD_EVAL = 2'b01,
        PCD_SLOPE = 2'b10
    } pcd_state_t;
endpackage

// [dv/pcd_host_model.sv]
/*
 host model: avalon-mm master that reads, writes and acknowledges events.
 assumes the bench calls its tasks from one process at a time.
*/
`timescale 1ns/1ns
module pcd_host_model (
    // clock
    input wire logic clock,
    // register bus
    output pcd_pkg::pcd_avreq_t avReq,
    input wire logic [31:0] avReadData,
    input wire logic avWaitRequest
);
    initial avReq = '0;

    // request held until waitrequest is seen low at a rising edge
    task automatic xfer(input logic wr, input logic [pcd_pkg::AW-1:0] addr,
            input logic [31:0] wdata, output logic [31:0] rdata);
        @(posedge clock);
        avReq.read <= ~wr;
        avReq.write <= wr;
        avReq.address <= addr;
        avReq.byteenable <= 4'hF;
        avReq.writedata <= wdata;
        @(posedge clock);
        while (avWaitRequest !== 1'b0) @(posedge clock);
        rdata = avReadData;
        avReq <= '0;
    endtask

    task automatic write(input logic [pcd_pkg::AW-1:0] addr,
            input logic [31:0] wdata);
        logic [31:0] unused;
        xfer(1'b1, addr, wdata, unused);
    endtask

    task automatic read(input logic [pcd_pkg::AW-1:0] addr,
            output logic [31:0] rdata);
        xfer(1'b0, addr, 32'h0000_0000, rdata);
    endtask

    // clears every sticky flag after a notification
    task automatic ack();
        write(pcd_pkg::OFS_CMD, 32'h0000_0001 << pcd_pkg::CMD_ACK);
    endtask
endmodule

// [dv/pcd_change_detector_bench.sv]
/*
 bench for the pressure change detector: register reads and writes through
 the host model, samples driven directly. assumes PMAX set to 16'h03FF.
*/
`timescale 1ns/1ns
module pcd_change_detector_bench;
    logic clock;
    logic rstn;
    logic sampleValid;
    logic [16:0] sampleRaw;
    pcd_pkg::pcd_avreq_t avReq;
    logic [31:0] avReadData;
    logic avWaitRequest;
    pcd_pkg::pcd_flags_t eventFlags;
    logic notifyFlag;
    logic pressureOverflow;
    int failures;
    int checked;
    int cycles;
    logic [31:0] rdata;
    logic [pcd_pkg::AW-1:0] rOfs [9] = '{pcd_pkg::OFS_CFG,
        pcd_pkg::OFS_DEBT, pcd_pkg::OFS_FIXT, pcd_pkg::OFS_MINT,
        pcd_pkg::OFS_RELT, pcd_pkg::OFS_SLOPET, pcd_pkg::OFS_STATUS,
        pcd_pkg::OFS_SENSTAT, 6'h2C};
    logic [31:0] rVal [9] = '{32'h1, 32'h5, 32'h320, 32'h3, 32'h32,
        32'h40, 32'h0, 32'h0, 32'h0};

    pcd_change_detector #(.RAW_W(17), .PMAX(16'h03FF), .FIFO_DEPTH(8)) u_dut (
        .clock(clock), .rstn(rstn), .avReq(avReq), .avReadData(avReadData),
        .avWaitRequest(avWaitRequest), .sampleValid(sampleValid),
        .sampleRaw(sampleRaw), .eventFlags(eventFlags),
        .notifyFlag(notifyFlag), .pressureOverflow(pressureOverflow));

    pcd_host_model u_host (.clock(clock), .avReq(avReq),
        .avReadData(avReadData), .avWaitRequest(avWaitRequest));

    always #2 clock = ~clock;

    task automatic stop_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            stop_test();
        end
    end

    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkBit(input logic got, input logic exp);
        checked = checked + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkReg(input logic [5:0] addr, input logic [31:0] exp);
        u_host.read(addr, rdata);
        chkWord(rdata, exp);
    endtask

    // one sample, then enough idle cycles for every flag to settle
    task automatic run(input logic [16:0] v, input logic [2:0] f);
        @(posedge clock);
        sampleValid <= 1'b1;
        sampleRaw <= v;
        @(posedge clock);
        sampleValid <= 1'b0;
        repeat (3) @(posedge clock);
        chkWord({29'h0, eventFlags}, {29'h0, f});
    endtask

    initial begin
        clock = 1'b0;
        rstn = 1'b0;
        sampleValid = 1'b0;
        sampleRaw = '0;
        failures = 0;
        checked = 0;
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        chkBit(notifyFlag, 1'b0);
        for (int i = 0; i < 9; i++) begin
            chkReg(rOfs[i], rVal[i]);
        end
        u_host.write(pcd_pkg::OFS_STATUS, 32'h0000_000F);
        chkReg(pcd_pkg::OFS_STATUS, 32'h0);
        $display("test reset done");

        u_host.write(pcd_pkg::OFS_DEBT, 32'h0);
        u_host.write(pcd_pkg::OFS_FIXT, 32'h100);
        run(17'h00100, 3'h0);
        run(17'h00101, 3'h1);
        chkBit(notifyFlag, 1'b1);
        chkReg(pcd_pkg::OFS_STATUS, 32'h9);
        u_host.ack();
        chkReg(pcd_pkg::OFS_STATUS, 32'h0);
        chkBit(notifyFlag, 1'b0);
        u_host.write(pcd_pkg::OFS_DEBT, 32'h1);
        run(17'h00100, 3'h0);
        run(17'h00101, 3'h0);
        run(17'h00100, 3'h0);
        run(17'h00101, 3'h0);
        run(17'h00101, 3'h1);
        $display("test fixed done");

        u_host.ack();
        u_host.write(pcd_pkg::OFS_CFG, 32'h2);
        run(17'h0012C, 3'h0);
        run(17'h0012F, 3'h0);
        run(17'h00168, 3'h0);
        run(17'h001A4, 3'h2);
        chkBit(notifyFlag, 1'b1);
        run(17'h001AE, 3'h2);
        chkReg(pcd_pkg::OFS_FIFODATA, 32'h1AE);
        u_host.write(pcd_pkg::OFS_FIFOSEL, 32'h1);
        chkReg(pcd_pkg::OFS_FIFODATA, 32'h1A4);
        u_host.write(pcd_pkg::OFS_FIFOSEL, 32'h0);
        $display("test relative done");

        u_host.ack();
        u_host.write(pcd_pkg::OFS_CFG, 32'h4);
        u_host.write(pcd_pkg::OFS_SLOPET, 32'h3C0);
        run(17'h001A4, 3'h0);
        run(17'h001AE, 3'h0);
        run(17'h001B8, 3'h0);
        run(17'h001C2, 3'h4);
        $display("test slope done");

        u_host.ack();
        u_host.write(pcd_pkg::OFS_CFG, 32'h0);
        run(17'h00500, 3'h0);
        chkBit(pressureOverflow, 1'b1);
        chkBit(notifyFlag, 1'b0);
        chkReg(pcd_pkg::OFS_SENSTAT, 32'h1);
        chkReg(pcd_pkg::OFS_FIFODATA, 32'h3FF);
        u_host.ack();
        u_host.write(pcd_pkg::OFS_CFG, 32'h8);
        run(17'h00500, 3'h0);
        chkBit(notifyFlag, 1'b1);
        $display("test overflow done");
        stop_test();
    end
endmodule
